// [hw/cilr_defs.vh]
// Constants of the CAN interrupt line router: offsets, field positions, reset values
`ifndef CILR_DEFS_VH
`define CILR_DEFS_VH

// ****************************************************************
// Widths
// ****************************************************************
`define CILR_NFLAG        30
`define CILR_NLINE        2

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CILR_OFS_SEL      8'h58
`define CILR_OFS_ENA      8'h5C
`define CILR_OFS_LST      8'h60
`define CILR_OFS_EVT      8'h64
`define CILR_OFS_MSK      8'h68
`define CILR_OFS_PND0     8'h6C
`define CILR_OFS_PND1     8'h70

// ****************************************************************
// Reset values
// ****************************************************************
`define CILR_RST_SEL      30'h00000000
`define CILR_RST_ENA      2'h0
`define CILR_RST_EVT      2'h0
`define CILR_RST_MSK      2'h0
`define CILR_RD_ZERO      32'h00000000

// ****************************************************************
// Line enable, event and mask bit positions
// ****************************************************************
`define CILR_LINE_ZERO    0
`define CILR_LINE_ONE     1

// ****************************************************************
// Line select field groups, high and low bit
// ****************************************************************
`define CILR_G_PROT_HI    29
`define CILR_G_PROT_LO    27
`define CILR_G_STATE_HI   26
`define CILR_G_STATE_LO   22
`define CILR_G_MEM_HI     21
`define CILR_G_MEM_LO     16
`define CILR_G_TXEVT_HI   15
`define CILR_G_TXEVT_LO   12
`define CILR_G_TXQ_HI     11
`define CILR_G_TXQ_LO     9
`define CILR_G_HPRIO      8
`define CILR_G_RXQ1_HI    7
`define CILR_G_RXQ1_LO    4
`define CILR_G_RXQ0_HI    3
`define CILR_G_RXQ0_LO    0

`endif

// [hw/cilr_route.v]
// Per-flag steering of enabled interrupt flags onto the two line candidates
`timescale 1ns/1ps
`include "cilr_defs.vh"

module cilr_route (
  input  wire [29:0] flag,
  input  wire [29:0] flag_en,
  input  wire [29:0] line_sel,
  output wire [29:0] pend_zero,
  output wire [29:0] pend_one
);

  genvar i;

  generate
    for (i = 0; i < `CILR_NFLAG; i = i + 1) begin : g_flag
      wire act;
      assign act          = flag[i] & flag_en[i];    // RL13
      assign pend_zero[i] = act & ~line_sel[i];      // RL1
      assign pend_one[i]  = act & line_sel[i];       // RL1
    end
  endgenerate

endmodule // cilr_route

// [hw/cilr_top.v]
// CAN interrupt line router with Wishbone register slave and event interrupt
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "cilr_defs.vh"

// How it works
// RL1: Select bit 0 routes line zero, 1 line one
// RL2: Routed source asserts only an enabled line
// RL3: Enable bit 0 gates line zero
// RL4: Enable bit 1 gates line one independently
// RL5: Bits 29-27 steer reserved access, protocol errors
// RL6: Bits 26-22 steer watchdog, bus states, overflow
// RL7: Bits 21-16 steer bit errors, buffer, timeout
// RL8: Bits 15-12 steer transmit event queue events
// RL9: Bits 11-9 steer queue empty, cancel, done
// RL10: Bit 8 steers high priority reception
// RL11: Bits 7-4 steer receive queue one events
// RL12: Bits 3-0 steer receive queue zero events
// RL13: Flag counts only with its enable bit
// RL14: Line is gated OR; reserved reads zero
// RL15: Reset clears selects and both enables
module cilr_top (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire        CE,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output wire [31:0] WB_DAT_O,
  output wire        WB_ACK_O,
  input  wire [29:0] FLAG_I,
  input  wire [29:0] FLAG_EN_I,
  output wire        IRQ_OUT_ZERO,
  output wire        IRQ_OUT_ONE,
  output wire        IRQ_EVT
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [29:0] sel_q;
  reg  [29:0] sel_d;
  reg  [1:0]  ena_q;
  reg  [1:0]  ena_d;
  reg  [1:0]  evt_q;
  reg  [1:0]  evt_d;
  reg  [1:0]  msk_q;
  reg  [1:0]  msk_d;
  reg         ack_q;
  reg         ack_d;
  reg  [31:0] rdat_q;
  reg  [31:0] rdat_d;
  reg         line_zero_q;
  reg         line_one_q;
  reg         irq_q;
  wire        line_zero_d;
  wire        line_one_d;
  wire [29:0] pend_zero;
  wire [29:0] pend_one;
  wire        any_zero;
  wire        any_one;
  wire        line_zero_gate;
  wire        line_one_gate;
  wire        req;
  wire        wr_fire;
  wire [7:0]  adr_word;
  wire        hit_sel;
  wire        hit_ena;
  wire        hit_lst;
  wire        hit_evt;
  wire        hit_msk;
  wire        hit_pnd0;
  wire        hit_pnd1;
  wire [31:0] sel_merged;
  wire [1:0]  evt_set;
  wire [1:0]  evt_clr;
  wire [29:0] line_sel;
  wire        sel_reserved_access;
  wire        sel_data_phase_err;
  wire        sel_arb_phase_err;
  wire        sel_ram_watchdog;
  wire        sel_bus_off;
  wire        sel_warning_state;
  wire        sel_error_passive;
  wire        sel_errlog_overflow;
  wire        sel_uncorrected_err;
  wire        sel_corrected_err;
  wire        sel_dedicated_rx_store;
  wire        sel_timeout;
  wire        sel_ram_access_fail;
  wire        sel_timestamp_wrap;
  wire        sel_txevt_lost;
  wire        sel_txevt_full;
  wire        sel_txevt_watermark;
  wire        sel_txevt_new;
  wire        sel_tx_queue_empty;
  wire        sel_cancel_done;
  wire        sel_tx_done;
  wire        sel_high_prio_rx;
  wire        sel_rxq1_lost;
  wire        sel_rxq1_full;
  wire        sel_rxq1_watermark;
  wire        sel_rxq1_new;
  wire        sel_rxq0_lost;
  wire        sel_rxq0_full;
  wire        sel_rxq0_watermark;
  wire        sel_rxq0_new;

  // ****************************************************************
  // Byte lane merge
  // ****************************************************************
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  lanes;
    integer      k;
    begin
      lane_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (lanes[k]) begin
          lane_merge[8*k +: 8] = new_val[8*k +: 8];
        end
      end
    end
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign req      = WB_CYC_I & WB_STB_I;
  assign adr_word = {WB_ADR_I[7:2], 2'b00};
  assign hit_sel  = (adr_word == `CILR_OFS_SEL);
  assign hit_ena  = (adr_word == `CILR_OFS_ENA);
  assign hit_lst  = (adr_word == `CILR_OFS_LST);
  assign hit_evt  = (adr_word == `CILR_OFS_EVT);
  assign hit_msk  = (adr_word == `CILR_OFS_MSK);
  assign hit_pnd0 = (adr_word == `CILR_OFS_PND0);
  assign hit_pnd1 = (adr_word == `CILR_OFS_PND1);

  // Write lands on the edge at which the master sees ack
  assign wr_fire  = ack_q & req & WB_WE_I;

  // Ack one cycle after the request, dropped in the cycle after
  always @* begin
    ack_d = req & ~ack_q;
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // ****************************************************************
  // Line select fields
  // ****************************************************************
  assign {sel_reserved_access,
          sel_data_phase_err,
          sel_arb_phase_err} = sel_q[`CILR_G_PROT_HI:`CILR_G_PROT_LO];         // RL5
  assign {sel_ram_watchdog,
          sel_bus_off,
          sel_warning_state,
          sel_error_passive,
          sel_errlog_overflow} = sel_q[`CILR_G_STATE_HI:`CILR_G_STATE_LO];     // RL6
  assign {sel_uncorrected_err,
          sel_corrected_err,
          sel_dedicated_rx_store,
          sel_timeout,
          sel_ram_access_fail,
          sel_timestamp_wrap} = sel_q[`CILR_G_MEM_HI:`CILR_G_MEM_LO];          // RL7
  assign {sel_txevt_lost,
          sel_txevt_full,
          sel_txevt_watermark,
          sel_txevt_new} = sel_q[`CILR_G_TXEVT_HI:`CILR_G_TXEVT_LO];           // RL8
  assign {sel_tx_queue_empty,
          sel_cancel_done,
          sel_tx_done} = sel_q[`CILR_G_TXQ_HI:`CILR_G_TXQ_LO];                 // RL9
  assign sel_high_prio_rx = sel_q[`CILR_G_HPRIO];                              // RL10
  assign {sel_rxq1_lost,
          sel_rxq1_full,
          sel_rxq1_watermark,
          sel_rxq1_new} = sel_q[`CILR_G_RXQ1_HI:`CILR_G_RXQ1_LO];              // RL11
  assign {sel_rxq0_lost,
          sel_rxq0_full,
          sel_rxq0_watermark,
          sel_rxq0_new} = sel_q[`CILR_G_RXQ0_HI:`CILR_G_RXQ0_LO];              // RL12

  assign line_sel = {sel_reserved_access, sel_data_phase_err, sel_arb_phase_err,
                     sel_ram_watchdog, sel_bus_off, sel_warning_state, sel_error_passive,
                     sel_errlog_overflow, sel_uncorrected_err, sel_corrected_err,
                     sel_dedicated_rx_store, sel_timeout, sel_ram_access_fail,
                     sel_timestamp_wrap, sel_txevt_lost, sel_txevt_full, sel_txevt_watermark,
                     sel_txevt_new, sel_tx_queue_empty, sel_cancel_done, sel_tx_done,
                     sel_high_prio_rx, sel_rxq1_lost, sel_rxq1_full, sel_rxq1_watermark,
                     sel_rxq1_new, sel_rxq0_lost, sel_rxq0_full, sel_rxq0_watermark,
                     sel_rxq0_new};

  // ****************************************************************
  // Steering of the flags
  // ****************************************************************
  cilr_route u_route (
    .flag      (FLAG_I),
    .flag_en   (FLAG_EN_I),
    .line_sel  (line_sel),
    .pend_zero (pend_zero),
    .pend_one  (pend_one)
  );

  assign any_zero       = |pend_zero;                       // RL14
  assign any_one        = |pend_one;                        // RL14
  assign line_zero_gate = ena_q[`CILR_LINE_ZERO];           // RL3
  assign line_one_gate  = ena_q[`CILR_LINE_ONE];            // RL4
  assign line_zero_d    = any_zero & line_zero_gate;        // RL2
  assign line_one_d     = any_one & line_one_gate;          // RL2

  assign IRQ_OUT_ZERO = line_zero_q;
  assign IRQ_OUT_ONE  = line_one_q;

  // ****************************************************************
  // Line select register
  // ****************************************************************
  assign sel_merged = lane_merge({2'b00, sel_q}, WB_DAT_I, WB_SEL_I);

  always @* begin
    sel_d = sel_q;
    if (wr_fire && hit_sel) begin
      sel_d[`CILR_G_PROT_HI:`CILR_G_PROT_LO] =
        sel_merged[`CILR_G_PROT_HI:`CILR_G_PROT_LO];     // RL5
      sel_d[`CILR_G_STATE_HI:`CILR_G_STATE_LO] =
        sel_merged[`CILR_G_STATE_HI:`CILR_G_STATE_LO];   // RL6
      sel_d[`CILR_G_MEM_HI:`CILR_G_MEM_LO] =
        sel_merged[`CILR_G_MEM_HI:`CILR_G_MEM_LO];       // RL7
      sel_d[`CILR_G_TXEVT_HI:`CILR_G_TXEVT_LO] =
        sel_merged[`CILR_G_TXEVT_HI:`CILR_G_TXEVT_LO];   // RL8
      sel_d[`CILR_G_TXQ_HI:`CILR_G_TXQ_LO] =
        sel_merged[`CILR_G_TXQ_HI:`CILR_G_TXQ_LO];       // RL9
      sel_d[`CILR_G_HPRIO] =
        sel_merged[`CILR_G_HPRIO];                       // RL10
      sel_d[`CILR_G_RXQ1_HI:`CILR_G_RXQ1_LO] =
        sel_merged[`CILR_G_RXQ1_HI:`CILR_G_RXQ1_LO];     // RL11
      sel_d[`CILR_G_RXQ0_HI:`CILR_G_RXQ0_LO] =
        sel_merged[`CILR_G_RXQ0_HI:`CILR_G_RXQ0_LO];     // RL12
    end
  end

  // ****************************************************************
  // Line enable register
  // ****************************************************************
  always @* begin
    ena_d = ena_q;
    if (wr_fire && hit_ena && WB_SEL_I[0]) begin
      ena_d[`CILR_LINE_ZERO] = WB_DAT_I[`CILR_LINE_ZERO];   // RL3
      ena_d[`CILR_LINE_ONE]  = WB_DAT_I[`CILR_LINE_ONE];    // RL4
    end
  end

  // ****************************************************************
  // Line events, sticky status and mask
  // ****************************************************************
  // A line rising is one event; a set in the clearing cycle wins
  assign evt_set = {line_one_d & ~line_one_q, line_zero_d & ~line_zero_q};
  assign evt_clr = (wr_fire && hit_evt && WB_SEL_I[0]) ? WB_DAT_I[1:0] : 2'b00;

  always @* begin
    evt_d = (evt_q & ~evt_clr) | evt_set;
  end

  always @* begin
    msk_d = msk_q;
    if (wr_fire && hit_msk && WB_SEL_I[0]) begin
      msk_d = WB_DAT_I[1:0];
    end
  end

  assign IRQ_EVT = irq_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Reserved and unmapped bits read as zero
  always @* begin
    rdat_d = `CILR_RD_ZERO;                                           // RL14
    case (1'b1)
      hit_sel: begin
        rdat_d = {2'b00, sel_q};
      end
      hit_ena: begin
        rdat_d = {30'h00000000, ena_q};
      end
      hit_lst: begin
        rdat_d = {28'h0000000, any_one, any_zero, line_one_q, line_zero_q};
      end
      hit_evt: begin
        rdat_d = {30'h00000000, evt_q};
      end
      hit_msk: begin
        rdat_d = {30'h00000000, msk_q};
      end
      hit_pnd0: begin
        rdat_d = {2'b00, pend_zero};
      end
      hit_pnd1: begin
        rdat_d = {2'b00, pend_one};
      end
      default: begin
        rdat_d = `CILR_RD_ZERO;
      end
    endcase
  end

  // ****************************************************************
  // Bus state
  // ****************************************************************
  always @(posedge REF_CLK) begin
    if (RST) begin
      ack_q  <= 1'b0;
      rdat_q <= `CILR_RD_ZERO;
    end else if (CE) begin
      ack_q <= ack_d;
      if (ack_d) begin
        rdat_q <= rdat_d;
      end
    end
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  always @(posedge REF_CLK) begin
    if (RST) begin
      sel_q <= `CILR_RST_SEL;   // RL15
      ena_q <= `CILR_RST_ENA;   // RL15
      evt_q <= `CILR_RST_EVT;
      msk_q <= `CILR_RST_MSK;
    end else if (CE) begin
      sel_q <= sel_d;
      ena_q <= ena_d;
      evt_q <= evt_d;
      msk_q <= msk_d;
    end
  end

  // ****************************************************************
  // Output lines
  // ****************************************************************
  always @(posedge REF_CLK) begin
    if (RST) begin
      line_zero_q <= 1'b0;
      line_one_q  <= 1'b0;
      irq_q       <= 1'b0;
    end else if (CE) begin
      line_zero_q <= line_zero_d;   // RL14
      line_one_q  <= line_one_d;    // RL14
      irq_q       <= |(evt_d & msk_d);
    end
  end

endmodule // cilr_top

// [testbench/cilr_cpu.sv]
// Model of the CPU side counting requests on both interrupt lines
`timescale 1ns/1ps
module cilr_cpu (
  input  wire       clk,
  input  wire       irq_a,
  input  wire       irq_b,
  output reg  [7:0] taken_a,
  output reg  [7:0] taken_b
);
  reg a_q;
  reg b_q;
  initial begin
    taken_a = 8'h00;
    taken_b = 8'h00;
    a_q = 1'b0;
    b_q = 1'b0;
  end
  // A level line counts once per rising edge
  always @(posedge clk) begin
    a_q <= irq_a;
    b_q <= irq_b;
    if (irq_a & ~a_q) taken_a <= taken_a + 8'h01;
    if (irq_b & ~b_q) taken_b <= taken_b + 8'h01;
  end
endmodule // cilr_cpu

// [testbench/cilr_top_properties.sv]
// Concurrent checks on the ports of the interrupt line router
`timescale 1ns/1ps
`include "cilr_defs.vh"
module cilr_props (
  input wire        REF_CLK,
  input wire        RST,
  input wire        CE,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_WE_I,
  input wire [7:0]  WB_ADR_I,
  input wire [3:0]  WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire        WB_ACK_O,
  input wire [29:0] FLAG_I,
  input wire [29:0] FLAG_EN_I,
  input wire        IRQ_OUT_ZERO,
  input wire        IRQ_OUT_ONE,
  input wire        IRQ_EVT
);
  reg  [29:0] s_q;
  reg  [1:0]  e_q;
  reg  [1:0]  m_q;
  wire [31:0] bm = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire        ac = WB_ACK_O & WB_CYC_I & WB_STB_I;
  wire        rd = ac & ~WB_WE_I;
  wire        wr = ac & WB_WE_I & CE;
  wire        unm = WB_ADR_I < `CILR_OFS_SEL || WB_ADR_I > `CILR_OFS_PND1 + 8'h03;
  wire        is_s = WB_ADR_I[7:2] == `CILR_OFS_SEL >> 2;
  wire        is_e = WB_ADR_I[7:2] == `CILR_OFS_ENA >> 2;
  wire        is_m = WB_ADR_I[7:2] == `CILR_OFS_MSK >> 2;
  // Shadow copies of the select, enable and mask registers
  always @(posedge REF_CLK)
    if (RST) begin
      s_q <= 30'h0;
      e_q <= 2'h0;
      m_q <= 2'h0;
    end else if (wr) begin
      if (is_s) s_q <= (s_q & ~bm[29:0]) | (WB_DAT_I[29:0] & bm[29:0]);
      if (is_e && WB_SEL_I[0]) e_q <= WB_DAT_I[1:0];
      if (is_m && WB_SEL_I[0]) m_q <= WB_DAT_I[1:0];
    end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_ack_answer: assert property (CE && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing");
  chk_ack_pulse: assert property (CE && WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  chk_line_zero: assert property (CE |=> IRQ_OUT_ZERO ==
    $past(e_q[0] & |(FLAG_I & FLAG_EN_I & ~s_q))) else $error("line zero wrong");
  chk_line_one: assert property (CE |=> IRQ_OUT_ONE ==
    $past(e_q[1] & |(FLAG_I & FLAG_EN_I & s_q))) else $error("line one wrong");
  chk_sel_readback: assert property (rd && is_s |-> WB_DAT_O == {2'h0, s_q})
    else $error("select readback wrong");
  chk_ena_readback: assert property (rd && is_e |-> WB_DAT_O == {30'h0, e_q})
    else $error("enable readback wrong");
  chk_unmapped_zero: assert property (rd && unm |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  chk_evt_raise: assert property (IRQ_OUT_ZERO && !$past(IRQ_OUT_ZERO) && m_q[0] &&
    $past(m_q[0]) |-> IRQ_EVT) else $error("event not raised");
  chk_evt_one: assert property (IRQ_OUT_ONE && !$past(IRQ_OUT_ONE) && m_q[1] &&
    $past(m_q[1]) |-> IRQ_EVT) else $error("event one not raised");
  chk_evt_masked: assert property (m_q == 2'h0 && $past(m_q) == 2'h0 |-> !IRQ_EVT)
    else $error("masked event seen");
  chk_reset_clear: assert property ($fell(RST) |->
    !(IRQ_OUT_ZERO | IRQ_OUT_ONE | WB_ACK_O | IRQ_EVT)) else $error("reset not clear");
  cover property (rd && unm);
  cover property ($rose(IRQ_OUT_ONE));
  cover property ($rose(IRQ_EVT));
  cover property (!CE && IRQ_OUT_ONE);
endmodule // cilr_props
bind cilr_top cilr_props u_cilr_props (.*);

// [testbench/test_can_interrupt_line_router.sv]
// Random and corner-case bench of the interrupt line router
`timescale 1ns/1ps
`include "cilr_defs.vh"
module test_can_interrupt_line_router;
  reg         clk = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [3:0]  sel = 4'h0;
  reg  [31:0] dw = 32'h0, rd, sw;
  reg  [29:0] fl = 30'h0, fe = 30'h0;
  reg  [1:0]  en;
  wire [31:0] dr;
  wire [7:0]  cpu_a, cpu_b;
  wire        ack, q0, q1, ev;
  integer     seed = 71, fail_count = 0, checked = 0, i, t;
  cilr_top u_cilr_top (.REF_CLK(clk), .RST(rst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr),
    .WB_ACK_O(ack), .FLAG_I(fl), .FLAG_EN_I(fe), .IRQ_OUT_ZERO(q0), .IRQ_OUT_ONE(q1),
    .IRQ_EVT(ev));
  cilr_cpu u_cilr_cpu (.clk(clk), .irq_a(q0), .irq_b(q1), .taken_a(cpu_a), .taken_b(cpu_b));
  function [1:0] ex(input [29:0] s, input [29:0] f, input [29:0] e, input [1:0] n);
    ex = {n[1] & |(f & e & s), n[0] & |(f & e & ~s)};
  endfunction
  task results;
    begin
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task cmp(input [8*10:1] nm, input [31:0] x, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== x) begin
        fail_count = fail_count + 1;
        $display("wrong value %0s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; dw <= d;
      t = 0;
      @(posedge clk);
      while (ack !== 1'b1 && t < 20) begin
        t = t + 1;
        @(posedge clk);
      end
      if (ack !== 1'b1) begin
        fail_count = fail_count + 1;
        results;
      end else begin
        rd = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
      end
    end
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wb(0, `CILR_OFS_SEL, 0); cmp("sel reset", 0, rd);
    wb(0, `CILR_OFS_ENA, 0); cmp("ena reset", 0, rd);
    cmp("lines rst", 0, {q1, q0});
    $display("reset test done");
    for (i = 0; i < 30; i = i + 1) begin
      wb(1, `CILR_OFS_ENA, 3); wb(1, `CILR_OFS_SEL, 1 << i);
      fl <= 30'h1 << i; fe <= ~30'h0; settle;
      cmp("bit steer", 2, {q1, q0});
      wb(0, `CILR_OFS_PND1, 0);
      cmp("pend one", 1 << i, rd);
      wb(0, `CILR_OFS_PND0, 0);
      cmp("pend zero", 0, rd);
      fe <= ~(30'h1 << i); settle;
      cmp("flag off", 0, {q1, q0});
    end
    cmp("cpu one", 30, cpu_b);
    cmp("cpu zero", 0, cpu_a);
    $display("steering test done");
    for (i = 0; i < 40; i = i + 1) begin
      sw = $random(seed); en = $random(seed);
      wb(1, `CILR_OFS_SEL, sw); wb(1, `CILR_OFS_ENA, {30'h0, en});
      fl <= $random(seed); fe <= $random(seed); settle;
      cmp("lines", ex(sw[29:0], fl, fe, en), {q1, q0});
      wb(0, `CILR_OFS_SEL, 0); cmp("sel read", {2'h0, sw[29:0]}, rd);
      wb(0, `CILR_OFS_ENA, 0);
      cmp("ena read", {30'h0, en}, rd);
    end
    $display("random test done");
    fl <= 30'h0; wb(1, `CILR_OFS_SEL, 0); wb(1, `CILR_OFS_ENA, 1);
    wb(1, `CILR_OFS_EVT, 3); wb(1, `CILR_OFS_MSK, 1);
    fl <= 30'h1; fe <= 30'h1; settle; cmp("evt raise", 1, ev);
    wb(1, `CILR_OFS_EVT, 1); settle; cmp("evt clear", 0, ev);
    wb(1, `CILR_OFS_MSK, 0); fl <= 30'h0; settle; fl <= 30'h1; settle;
    cmp("evt masked", 0, ev);
    wb(1, `CILR_OFS_MSK, 1); settle; cmp("evt sticky", 1, ev);
    wb(1, `CILR_OFS_ENA, 3);
    wb(1, `CILR_OFS_MSK, 2);
    wb(1, `CILR_OFS_SEL, 1);
    settle;
    cmp("evt one", 1, ev);
    wb(0, `CILR_OFS_LST, 0);
    cmp("lst read", 32'h0000000A, rd);
    wb(0, `CILR_OFS_EVT, 0);
    cmp("evt read", 3, rd);
    wb(1, `CILR_OFS_EVT, 2);
    settle;
    cmp("evt clr1", 0, ev);
    wb(0, `CILR_OFS_EVT, 0);
    cmp("evt left", 1, rd);
    $display("event test done");
    wb(1, 8'h7C, 32'hFFFFFFFF); wb(0, 8'h7C, 0); cmp("unmapped", 0, rd);
    cmp("cpu saw", 1, cpu_b != 8'h00);
    $display("unmapped test done");
    ce <= 1'b0;
    fl <= 30'h0;
    settle;
    cmp("ce hold", 2, {q1, q0});
    ce <= 1'b1;
    settle;
    cmp("ce resume", 0, {q1, q0});
    fl <= 30'h1;
    wb(1, `CILR_OFS_SEL, 32'h3FFFFFFF);
    wb(1, `CILR_OFS_ENA, 3);
    settle;
    cmp("pre reset", 2, {q1, q0});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cmp("evt rst", 0, ev);
    wb(0, `CILR_OFS_SEL, 0);
    cmp("sel rst2", 0, rd);
    wb(0, `CILR_OFS_ENA, 0);
    cmp("ena rst2", 0, rd);
    cmp("lines rs2", 0, {q1, q0});
    $display("enable and reset test done");
    results;
  end
endmodule // test_can_interrupt_line_router
